// >>> design/acms_consts.svh
// Purpose: constants for the converter mode sequencer
// Assumes: 25 MHz clock
// Notes:   offsets of mode field codes and timing counts
`ifndef ACMS_CONSTS_SVH
`define ACMS_CONSTS_SVH

`define ACMS_MODE_FIXED_SINGLE 2'h0
`define ACMS_MODE_FIXED_CONT   2'h1
`define ACMS_MODE_SCAN_SINGLE  2'h2
`define ACMS_MODE_SCAN_CONT    2'h3
`define ACMS_CONV_TIME_NS      400
`define ACMS_CLK_PERIOD_NS     40
`define ACMS_CONV_CYCLES       ((`ACMS_CONV_TIME_NS + `ACMS_CLK_PERIOD_NS - 1) / `ACMS_CLK_PERIOD_NS)
`define ACMS_CH_W              4

`endif

// >>> design/acms_conv_timer.sv
// Purpose: counts out one conversion time
// Assumes: start only while not running
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "acms_consts.svh"
module acms_conv_timer (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic start,
  output var  logic done
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (start) begin
      next_count = 8'(`ACMS_CONV_CYCLES);
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
      next_done  = (count == 8'h01);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= 8'h00;
      done  <= 1'b0;
    end else if (enable) begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule
`default_nettype wire

// >>> design/acms_pkg.sv
// Purpose: types for the converter mode sequencer
// Assumes: nothing
// Notes:   one-hot state codes
package acms_pkg;
  typedef enum logic [2:0] {
    ACMS_IDLE = 3'h1,
    ACMS_CONV = 3'h2,
    ACMS_NEXT = 3'h4
  } acms_state_t;
endpackage

// >>> design/adc_conversion_mode_sequencer.sv
// Purpose: conversion mode, channel and start sequencing for the converter
// Assumes: control register writes arrive as a one-cycle write strobe with fields
// Notes:   reproduces the idle mode-change auto scan start
`timescale 1ns/1ps
`default_nettype none
`include "acms_consts.svh"
module adc_conversion_mode_sequencer (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 clkEnable,
  input  wire logic                 controlWrite,
  input  wire logic [1:0]           conversionModeField,
  input  wire logic [`ACMS_CH_W-1:0] channelSelectField,
  input  wire logic                 conversionStartBit,
  output var  logic                 converterBusyFlag,
  output var  logic [`ACMS_CH_W-1:0] activeChannel,
  output var  logic                 conversionDone
);
  // ----------------------------------------------------------------
  // control register image
  // ----------------------------------------------------------------
  logic [1:0]            modeReg;
  logic [`ACMS_CH_W-1:0] chanReg;
  logic                  startReg;
  logic [1:0]            next_modeReg;
  logic [`ACMS_CH_W-1:0] next_chanReg;
  logic                  next_startReg;

  acms_pkg::acms_state_t state;
  acms_pkg::acms_state_t next_state;
  logic [1:0]            runMode;
  logic [1:0]            next_runMode;
  logic [`ACMS_CH_W-1:0] next_activeChannel;
  logic [`ACMS_CH_W-1:0] lastChan;
  logic [`ACMS_CH_W-1:0] next_lastChan;
  logic                  lastWasFixed;
  logic                  next_lastWasFixed;
  logic                  oneShotScan;
  logic                  next_oneShotScan;
  logic                  next_busy;
  logic                  timerStart;
  logic                  timerDone;
  logic                  isScan;
  logic                  newIsScan;

  assign isScan    = runMode[1];
  assign newIsScan = conversionModeField[1];

  acms_conv_timer u_acms_conv_timer (
    .clk    (clk),
    .reset  (reset),
    .enable (clkEnable),
    .start  (timerStart),
    .done   (timerDone)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_modeReg       = modeReg;
    next_chanReg       = chanReg;
    next_startReg      = startReg;
    next_state         = state;
    next_runMode       = runMode;
    next_activeChannel = activeChannel;
    next_lastChan      = lastChan;
    next_lastWasFixed  = lastWasFixed;
    next_oneShotScan   = oneShotScan;
    next_busy          = converterBusyFlag;
    timerStart         = 1'b0;
    if (controlWrite) begin
      next_modeReg  = conversionModeField;
      next_chanReg  = channelSelectField;
      next_startReg = conversionStartBit;
    end
    unique case (state)
      acms_pkg::ACMS_IDLE: begin
        next_busy = 1'b0;
        if (controlWrite && conversionStartBit) begin
          next_state         = acms_pkg::ACMS_CONV;
          next_runMode       = conversionModeField;
          next_activeChannel = channelSelectField;
          next_busy          = 1'b1;
          next_startReg      = 1'b0;
          next_oneShotScan   = 1'b0;
          timerStart         = 1'b1;
        end else if (controlWrite && newIsScan && !modeReg[1] && lastWasFixed
                     && lastChan != '0) begin
          // written channel is ignored: start is one below the last converted one
          next_state         = acms_pkg::ACMS_CONV;
          next_runMode       = `ACMS_MODE_SCAN_SINGLE;
          next_activeChannel = lastChan - 4'h1;
          next_oneShotScan   = 1'b1;
          next_busy          = 1'b1;
          timerStart         = 1'b1;
        end
      end
      acms_pkg::ACMS_CONV: begin
        next_busy = 1'b1;
        if (timerDone) begin
          next_lastChan     = activeChannel;
          next_lastWasFixed = !isScan;
          next_state        = acms_pkg::ACMS_NEXT;
        end
      end
      acms_pkg::ACMS_NEXT: begin
        // register image only now evaluated, so mid-conversion writes wait
        next_state = acms_pkg::ACMS_CONV;
        timerStart = 1'b1;
        if (!isScan && modeReg[1] && lastChan != '0) begin
          next_runMode       = modeReg;
          next_activeChannel = lastChan - 4'h1;
        end else if (!isScan) begin
          next_runMode = modeReg;
          if (modeReg == `ACMS_MODE_FIXED_CONT || startReg) begin
            next_activeChannel = chanReg;
            // a start written in this very cycle stays pending
            next_startReg      = controlWrite && conversionStartBit;
          end else begin
            next_state = acms_pkg::ACMS_IDLE;
            timerStart = 1'b0;
            next_busy  = 1'b0;
          end
        end else if (lastChan != '0) begin
          // the unintended scan stays single whatever mode is written meanwhile
          next_runMode       = oneShotScan ? runMode : modeReg;
          next_activeChannel = (modeReg[1] || oneShotScan) ? lastChan - 4'h1 : chanReg;
        end else if (runMode == `ACMS_MODE_SCAN_CONT || startReg) begin
          next_runMode       = modeReg;
          next_activeChannel = chanReg;
          next_startReg      = controlWrite && conversionStartBit;
          next_oneShotScan   = 1'b0;
        end else begin
          next_state       = acms_pkg::ACMS_IDLE;
          timerStart       = 1'b0;
          next_oneShotScan = 1'b0;
          next_busy        = 1'b0;
        end
      end
      default: begin
        next_state = acms_pkg::ACMS_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modeReg           <= 2'h0;
      chanReg           <= '0;
      startReg          <= 1'b0;
      state             <= acms_pkg::ACMS_IDLE;
      runMode           <= 2'h0;
      activeChannel     <= '0;
      lastChan          <= '0;
      lastWasFixed      <= 1'b0;
      oneShotScan       <= 1'b0;
      converterBusyFlag <= 1'b0;
      conversionDone    <= 1'b0;
    end else if (clkEnable) begin
      modeReg           <= next_modeReg;
      chanReg           <= next_chanReg;
      startReg          <= next_startReg;
      state             <= next_state;
      runMode           <= next_runMode;
      activeChannel     <= next_activeChannel;
      lastChan          <= next_lastChan;
      lastWasFixed      <= next_lastWasFixed;
      oneShotScan       <= next_oneShotScan;
      converterBusyFlag <= next_busy;
      conversionDone    <= timerDone;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_IDLE_NOT_BUSY: assert property (@(posedge clk) disable iff (reset)
    (state == acms_pkg::ACMS_IDLE && $past(state) == acms_pkg::ACMS_IDLE && clkEnable
     && $past(clkEnable)) |-> !converterBusyFlag)
    else $error("busy set while idle");
  AST_START_BUSY: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_IDLE && controlWrite && conversionStartBit)
    |=> converterBusyFlag && activeChannel == $past(channelSelectField))
    else $error("start did not raise busy at selected channel");
  AST_SCAN_DESC: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_NEXT && isScan && modeReg[1] && lastChan != '0)
    |=> activeChannel == $past(lastChan) - 1'b1)
    else $error("scan channel not descending");
  AST_ERRATUM: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_IDLE && controlWrite && !conversionStartBit
     && newIsScan && !modeReg[1] && lastWasFixed && lastChan != '0)
    |=> converterBusyFlag && runMode == `ACMS_MODE_SCAN_SINGLE)
    else $error("unintended scan not started");
  AST_ERRATUM_CHAN: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_IDLE && controlWrite && !conversionStartBit
     && newIsScan && !modeReg[1] && lastWasFixed && lastChan != '0)
    |=> activeChannel == $past(lastChan) - 1'b1)
    else $error("unintended scan used written channel");
  AST_MODE_HELD: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_CONV && $past(state) == acms_pkg::ACMS_CONV
     && $past(clkEnable)) |-> $stable(runMode))
    else $error("mode changed mid conversion");
  AST_CHAN_HELD: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_CONV && $past(clkEnable)
     && $past(state) == acms_pkg::ACMS_CONV) |-> $stable(activeChannel))
    else $error("channel changed mid conversion");
  AST_BUSY_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_NEXT && next_state == acms_pkg::ACMS_IDLE)
    |=> !converterBusyFlag)
    else $error("busy not cleared after last conversion");
  AST_SWITCH_SCAN: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_NEXT && !isScan && modeReg[1] && lastChan != '0)
    |=> runMode[1] && activeChannel == $past(lastChan) - 1'b1)
    else $error("fixed to scan switch did not continue downward");
  AST_ONESHOT_END: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && state == acms_pkg::ACMS_NEXT && oneShotScan && lastChan == '0 && !startReg)
    |=> state == acms_pkg::ACMS_IDLE && !converterBusyFlag)
    else $error("unintended scan did not stop after channel 0");
  COV_START: cover property (@(posedge clk) clkEnable && controlWrite && conversionStartBit);
  COV_ERRATUM: cover property (@(posedge clk) clkEnable && state == acms_pkg::ACMS_IDLE
    && controlWrite && newIsScan && !conversionStartBit && lastWasFixed);
  COV_SCAN_END: cover property (@(posedge clk) state == acms_pkg::ACMS_NEXT && isScan
    && lastChan == '0);
  COV_FIXED_CONT: cover property (@(posedge clk) clkEnable && state == acms_pkg::ACMS_NEXT
    && runMode == `ACMS_MODE_FIXED_CONT);
endmodule
`default_nettype wire

// >>> verification/adc_conversion_mode_sequencer_test.sv
// Purpose: self-checking bench for the converter mode sequencer
// Assumes: 25 MHz clock, one-cycle control write strobe
// Notes:   outputs sampled on the falling edge, inputs driven on the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "acms_consts.svh"
module adc_conversion_mode_sequencer_test;
  logic                  clk;
  logic                  reset;
  logic                  clkEnable;
  logic                  controlWrite;
  logic [1:0]            conversionModeField;
  logic [`ACMS_CH_W-1:0] channelSelectField;
  logic                  conversionStartBit;
  logic                  converterBusyFlag;
  logic [`ACMS_CH_W-1:0] activeChannel;
  logic                  conversionDone;
  int                    failCount;
  int                    checks;

  adc_conversion_mode_sequencer u_adc_conversion_mode_sequencer (
    .clk                 (clk),
    .reset               (reset),
    .clkEnable           (clkEnable),
    .controlWrite        (controlWrite),
    .conversionModeField (conversionModeField),
    .channelSelectField  (channelSelectField),
    .conversionStartBit  (conversionStartBit),
    .converterBusyFlag   (converterBusyFlag),
    .activeChannel       (activeChannel),
    .conversionDone      (conversionDone)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic writeCtl(input logic [1:0] mode, input logic [3:0] ch, input logic st);
    @(posedge clk);
    controlWrite        <= 1'b1;
    conversionModeField <= mode;
    channelSelectField  <= ch;
    conversionStartBit  <= st;
    @(posedge clk);
    controlWrite        <= 1'b0;
  endtask

  // one conversion takes 12 cycles, so 40 leaves ample slack without hiding a hang
  task automatic expectConv(input logic [3:0] ch);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conversionDone !== 1'b1 && n < 40);
    check("conversionDone", conversionDone, 1'b1);
    check("activeChannel", activeChannel, ch);
    check("busyDuringConversion", converterBusyFlag, 1'b1);
  endtask

  task automatic expectIdle;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (converterBusyFlag !== 1'b0 && n < 3);
    check("busyIdle", converterBusyFlag, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testFixed;
    logic sawDone;
    sawDone = 1'b0;
    writeCtl(`ACMS_MODE_FIXED_SINGLE, 4'h5, 1'b1);
    @(posedge clk);
    clkEnable <= 1'b0;
    repeat (30) begin
      @(negedge clk);
      sawDone = sawDone | conversionDone;
    end
    check("doneWhileFrozen", sawDone, 1'b0);
    check("busyWhileFrozen", converterBusyFlag, 1'b1);
    @(posedge clk);
    clkEnable <= 1'b1;
    expectConv(4'h5);
    expectIdle();
    repeat (20) @(negedge clk);
    check("busyStaysIdle", converterBusyFlag, 1'b0);
    $display("test fixed single done");
  endtask

  // mode change from idle without start: scan from 4, written channel ignored
  task automatic testErratum;
    writeCtl(`ACMS_MODE_SCAN_CONT, 4'h9, 1'b0);
    for (int c = 4; c >= 0; c--) expectConv(c[3:0]);
    expectIdle();
    $display("test idle mode change done");
  endtask

  task automatic testSwitch;
    writeCtl(`ACMS_MODE_FIXED_SINGLE, 4'h6, 1'b1);
    repeat (3) @(posedge clk);
    writeCtl(`ACMS_MODE_SCAN_SINGLE, 4'h6, 1'b0);
    expectConv(4'h6);
    for (int c = 5; c >= 0; c--) expectConv(c[3:0]);
    expectIdle();
    $display("test switch during conversion done");
  endtask

  task automatic testCont;
    writeCtl(`ACMS_MODE_SCAN_CONT, 4'h2, 1'b1);
    for (int c = 2; c >= 0; c--) expectConv(c[3:0]);
    expectConv(4'h2);
    writeCtl(`ACMS_MODE_SCAN_SINGLE, 4'h7, 1'b0);
    expectConv(4'h1);
    expectConv(4'h0);
    expectIdle();
    $display("test continuous scan done");
  endtask

  // continuous fixed channel repeats until the mode is rewritten
  task automatic testFixedCont;
    writeCtl(`ACMS_MODE_FIXED_CONT, 4'h3, 1'b1);
    expectConv(4'h3);
    expectConv(4'h3);
    writeCtl(`ACMS_MODE_FIXED_SINGLE, 4'h3, 1'b0);
    expectConv(4'h3);
    expectIdle();
    $display("test continuous fixed done");
  endtask

  task automatic testReset;
    writeCtl(`ACMS_MODE_SCAN_SINGLE, 4'h3, 1'b1);
    expectConv(4'h3);
    expectConv(4'h2);
    @(posedge clk);
    reset <= 1'b1;
    @(negedge clk);
    check("busyInReset", converterBusyFlag, 1'b0);
    check("channelInReset", activeChannel, 4'h0);
    check("doneInReset", conversionDone, 1'b0);
    @(posedge clk);
    reset <= 1'b0;
    repeat (40) @(negedge clk);
    check("busyAfterReset", converterBusyFlag, 1'b0);
    $display("test reset mid-scan done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run is near 400 cycles; 5000 only trips on a real hang
  initial begin
    #(40 * 5000);
    failCount++;
    wrapUp();
  end

  initial begin
    clk                 = 1'b0;
    reset               = 1'b1;
    clkEnable           = 1'b1;
    controlWrite        = 1'b0;
    conversionModeField = 2'h0;
    channelSelectField  = 4'h0;
    conversionStartBit  = 1'b0;
    failCount           = 0;
    checks              = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("busyAfterPowerUp", converterBusyFlag, 1'b0);
    testFixed();
    testErratum();
    testSwitch();
    testCont();
    testFixedCont();
    testReset();
    wrapUp();
  end
endmodule
`default_nettype wire
